// File: logic/status_guard_pkg.sv
package status_guard_pkg;
  localparam logic [7:0] OP_SET_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE= 8'h01;
  localparam logic [7:0] OP_ARRAY_READ  = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_CLOCK_READ  = 8'h13;
  localparam logic [7:0] OP_CLOCK_WRITE = 8'h12;
  localparam logic [7:0] OP_SAVE        = 8'h3C;
  localparam logic [7:0] OP_RESTORE     = 8'h60;
  localparam logic [7:0] OP_AUTOSAVE_ON = 8'h59;
  localparam logic [7:0] OP_AUTOSAVE_OFF= 8'h19;
  localparam int BIT_READY      = 0;
  localparam int BIT_LATCH      = 1;
  localparam int BIT_GUARD_LO   = 2;
  localparam int BIT_GUARD_HI   = 3;
  localparam int BIT_PIN_GUARD  = 7;
  localparam logic [7:0] STATUS_WRITABLE_MASK = 8'h8C;
  localparam logic [7:0] STATUS_SHIPPED = 8'h00;
  localparam logic [2:0] NV_SHIPPED     = 3'h0;
  localparam logic [14:0] GUARD1_BASE = 15'h6000;
  localparam logic [14:0] GUARD2_BASE = 15'h4000;
  localparam logic [14:0] GUARD3_BASE = 15'h0000;
  localparam logic [3:0] SPI_HALF_PERIOD = 4'h2;
  localparam logic [2:0] BITS_LAST      = 3'h7;
  localparam logic [1:0] REG_CMD        = 2'h0;
  localparam logic [1:0] REG_DATA       = 2'h1;
  localparam logic [1:0] REG_STATUS     = 2'h2;
endpackage

// File: logic/status_guard_if.sv
interface status_guard_if;
  logic select_b;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_b;
  logic protect_pin_b;
  modport device (input select_b, input sclk, input mosi,
                  input protect_pin_b, output miso, output miso_oe_b);
  modport host (output select_b, output sclk, output mosi,
                output protect_pin_b, input miso, input miso_oe_b);
endinterface

// File: logic/status_guard_device.sv
// The implementer's own choices: the address map and the plain strobed port.
module status_guard_device
  import status_guard_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  status_guard_if.device   bus,
  input  wire logic        i_nv_busy,
  input  wire logic [2:0]  i_nv_saved,
  input  wire logic [14:0] i_array_addr,
  output logic             o_array_write_ok,
  output logic             o_save_req,
  output logic             o_restore_req,
  output logic [2:0]       o_nv_image,
  output logic [7:0]       o_status
);
  typedef struct packed {
    logic       sel_q;
    logic       sclk_q;
    logic       loaded;
    logic       latch;
    logic       guard_lo;
    logic       guard_hi;
    logic       pin_guard;
    logic [2:0] spare;
    logic [7:0] shift;
    logic [2:0] cnt;
    logic       have_op;
    logic [7:0] op;
    logic       dead;
    logic       wr_allowed;
    logic       clr_at_end;
    logic       miso;
    logic       miso_oe_b;
    logic       wok;
    logic       save;
    logic       restore;
    logic [7:0] tx;
  } state_t;
  state_t s_reg;
  state_t s_next;
  logic [7:0] status_now;
  logic       is_write_class;
  logic [7:0] byte_in;

  always_comb begin
    s_next = s_reg;
    status_now = {s_reg.pin_guard, s_reg.spare, s_reg.guard_hi,
                  s_reg.guard_lo, s_reg.latch, i_nv_busy};
    byte_in = {s_reg.shift[6:0], bus.mosi};
    is_write_class = (byte_in == OP_STATUS_WRITE) ||
                     (byte_in == OP_ARRAY_WRITE) ||
                     (byte_in == OP_CLOCK_WRITE) || (byte_in == OP_SAVE) ||
                     (byte_in == OP_RESTORE) ||
                     (byte_in == OP_AUTOSAVE_ON) ||
                     (byte_in == OP_AUTOSAVE_OFF);
    s_next.sel_q = bus.select_b;
    s_next.sclk_q = bus.sclk;
    s_next.save = 1'b0;
    s_next.restore = 1'b0;
    // Nonvolatile guard bits are taken once after reset release.
    if (!s_reg.loaded) begin
      s_next.loaded = 1'b1;
      {s_next.pin_guard, s_next.guard_hi, s_next.guard_lo} = i_nv_saved;
    end
    if (!s_reg.sel_q && bus.select_b) begin
      if (s_reg.clr_at_end) begin
        s_next.latch = 1'b0;
      end
      s_next.clr_at_end = 1'b0;
      s_next.miso_oe_b = 1'b1;
    end
    if (s_reg.sel_q && !bus.select_b) begin
      s_next.cnt = 3'h0;
      s_next.have_op = 1'b0;
      s_next.dead = 1'b0;
      s_next.miso_oe_b = 1'b1;
    end
    if (!bus.select_b && !s_reg.dead && bus.sclk && !s_reg.sclk_q) begin
      s_next.shift = byte_in;
      s_next.cnt = s_reg.cnt + 3'h1;
      if (s_reg.cnt == BITS_LAST) begin
        if (!s_reg.have_op) begin
          s_next.have_op = 1'b1;
          s_next.op = byte_in;
          s_next.tx = status_now;
          if (byte_in == OP_SET_LATCH) begin
            s_next.latch = 1'b1;
          end else if (byte_in == OP_CLEAR_LATCH) begin
            s_next.clr_at_end = 1'b1;
          end else if (is_write_class && !s_reg.latch) begin
            s_next.dead = 1'b1;
          end else if (is_write_class) begin
            s_next.clr_at_end = 1'b1;
            // Protect pin is judged at the opcode only.
            s_next.wr_allowed = !(s_reg.pin_guard && !bus.protect_pin_b);
            s_next.save = byte_in == OP_SAVE;
            s_next.restore = byte_in == OP_RESTORE;
          end else if (byte_in != OP_STATUS_READ &&
                       byte_in != OP_ARRAY_READ &&
                       byte_in != OP_CLOCK_READ) begin
            s_next.dead = 1'b1;
          end
        end else if (s_reg.op == OP_STATUS_WRITE) begin
          if (s_reg.wr_allowed) begin
            s_next.pin_guard = byte_in[BIT_PIN_GUARD];
            s_next.guard_hi = byte_in[BIT_GUARD_HI];
            s_next.guard_lo = byte_in[BIT_GUARD_LO];
          end
          s_next.dead = 1'b1;
        end else begin
          s_next.tx = status_now;
        end
      end
    end
    if (!bus.select_b && s_reg.have_op && s_reg.op == OP_STATUS_READ &&
        !bus.sclk && s_reg.sclk_q) begin
      s_next.miso = s_reg.tx[~s_reg.cnt];
      s_next.miso_oe_b = 1'b0;
    end
    // Protected ranges only gate the array strobe.
    case ({s_reg.guard_hi, s_reg.guard_lo})
      2'b01: s_next.wok = i_array_addr < GUARD1_BASE;
      2'b10: s_next.wok = i_array_addr < GUARD2_BASE;
      2'b11: s_next.wok = 1'b0;
      default: s_next.wok = 1'b1;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      s_reg <= '0;
      s_reg.sel_q <= 1'b1;
      s_reg.miso_oe_b <= 1'b1;
      s_reg.wok <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.miso = s_reg.miso;
  assign bus.miso_oe_b = s_reg.miso_oe_b;
  assign o_array_write_ok = s_reg.wok;
  assign o_save_req = s_reg.save;
  assign o_restore_req = s_reg.restore;
  assign o_nv_image = {s_reg.pin_guard, s_reg.guard_hi, s_reg.guard_lo};
  assign o_status = {s_reg.pin_guard, s_reg.spare, s_reg.guard_hi,
                     s_reg.guard_lo, s_reg.latch, 1'b0};
endmodule // status_guard_device

// File: logic/status_guard_host.sv
module status_guard_host
  import status_guard_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  status_guard_if.host    bus,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_protect_level,
  output logic [7:0]      o_rdata
);
  typedef struct packed {
    logic       sel_b;
    logic       sclk;
    logic       mosi;
    logic       busy;
    logic [1:0] nbytes;
    logic [15:0] out;
    logic [3:0] div;
    logic [4:0] bits;
    logic [7:0] rx;
    logic [7:0] data;
    logic [7:0] rdata;
  } state_t;
  state_t s_reg;
  state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        REG_DATA:   s_next.rdata = s_reg.data;
        REG_STATUS: s_next.rdata = {7'h00, s_reg.busy};
        default:    s_next.rdata = s_reg.rx;
      endcase
    end
    if (i_wr && i_addr == REG_DATA) begin
      s_next.data = i_wdata & STATUS_WRITABLE_MASK;
    end
    if (i_wr && i_addr == REG_CMD && !s_reg.busy) begin
      // A status write always carries its data byte.
      s_next.busy = 1'b1;
      s_next.sel_b = 1'b0;
      s_next.out = {i_wdata, s_reg.data};
      s_next.nbytes = (i_wdata == OP_STATUS_WRITE ||
                       i_wdata == OP_STATUS_READ) ? 2'h2 : 2'h1;
      s_next.bits = 5'h0;
      s_next.div = 4'h0;
      s_next.mosi = i_wdata[7];
    end else if (s_reg.busy) begin
      s_next.div = s_reg.div + 4'h1;
      if (s_reg.div == SPI_HALF_PERIOD) begin
        s_next.div = 4'h0;
        if (s_reg.bits == {s_reg.nbytes, 3'h0}) begin
          s_next.sel_b = 1'b1;
          s_next.busy = 1'b0;
        end else if (!s_reg.sclk) begin
          s_next.sclk = 1'b1;
          s_next.rx = {s_reg.rx[6:0], bus.miso};
        end else begin
          s_next.sclk = 1'b0;
          s_next.bits = s_reg.bits + 5'h1;
          s_next.out = {s_reg.out[14:0], 1'b0};
          s_next.mosi = s_reg.out[14];
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      s_reg <= '0;
      s_reg.sel_b <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.select_b = s_reg.sel_b;
  assign bus.sclk = s_reg.sclk;
  assign bus.mosi = s_reg.mosi;
  assign bus.protect_pin_b = i_protect_level;
  assign o_rdata = s_reg.rdata;
endmodule // status_guard_host

// File: verification/status_guard_assertions.sv
module status_guard_assertions (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic select_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sclk_reg;
  logic [2:0] bits_reg;
  // Counts clock rises per frame so a frame can be judged whole bytes.
  always_ff @(posedge i_clock) begin
    sclk_reg <= sclk;
    if (!i_rst_b || select_b)
      bits_reg <= 3'h0;
    else if (sclk && !sclk_reg)
      bits_reg <= bits_reg + 3'h1;
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_open; $fell(select_b); endsequence
  sequence s_first_rise; ##[1:40] $rose(sclk); endsequence
  sequence s_high_bit; $rose(sclk) ##0 sclk [*2]; endsequence
  // The output enable is registered, so it lets go one edge after release.
  property p_oe_idle;
    select_b && $past(select_b) |-> miso_oe_b;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while idle");
  property p_sclk_idle; select_b |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("clock not idle");
  property p_quiet; s_open |-> miso_oe_b [*4]; endproperty
  a_quiet: assert property (p_quiet)
    else $error("output driven during opcode");
  property p_bytes; $rose(select_b) |-> bits_reg == 3'h0; endproperty
  a_bytes: assert property (p_bytes)
    else $error("frame not whole bytes");
  property p_high; $rose(sclk) |-> s_high_bit; endproperty
  a_high: assert property (p_high)
    else $error("clock high too short");
  property p_mosi; sclk && $past(sclk) |-> $stable(mosi); endproperty
  a_mosi: assert property (p_mosi)
    else $error("data in moved while clock high");
  property p_miso;
    !miso_oe_b && sclk && $past(sclk) |-> $stable(miso);
  endproperty
  a_miso: assert property (p_miso)
    else $error("data out moved while clock high");
  property p_start; s_open |-> s_first_rise; endproperty
  a_start: assert property (p_start)
    else $error("frame never clocked");
endmodule // status_guard_assertions

// File: verification/tb_top.sv
module tb_top
  import status_guard_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clock = 0;
  logic        i_rst_b = 0;
  logic        i_wr    = 0;
  logic        i_rd    = 0;
  logic        busy    = 0;
  logic        lvl     = 1;
  logic        ok;
  logic [1:0]  addr    = 2'h0;
  logic [7:0]  wdata   = 8'h00;
  logic [7:0]  status;
  logic [7:0]  rdata;
  logic [2:0]  saved   = 3'h0;
  logic [14:0] aaddr   = 15'h0000;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  // Row layout: status byte, array address, expected writable flag.
  logic [23:0] rows [6] = '{24'h00FFFF, 24'h04BFFF, 24'h04C000,
                            24'h087FFF, 24'h088000, 24'h0C0000};
  logic [7:0]  ops [4] = '{OP_SAVE, OP_RESTORE, OP_AUTOSAVE_ON,
                           OP_AUTOSAVE_OFF};
  status_guard_if bus ();
  always #2.5 i_clock = ~i_clock;
  status_guard_host i_status_guard_host (.i_clock, .i_rst_b,
    .bus(bus.host), .i_addr(addr), .i_wdata(wdata), .i_wr, .i_rd,
    .i_protect_level(lvl), .o_rdata(rdata));
  status_guard_device i_status_guard_device (.i_clock, .i_rst_b,
    .bus(bus.device), .i_nv_busy(busy), .i_nv_saved(saved),
    .i_array_addr(aaddr), .o_array_write_ok(ok), .o_save_req(),
    .o_restore_req(), .o_nv_image(), .o_status(status));
  status_guard_assertions i_status_guard_assertions (.i_clock,
    .i_rst_b, .select_b(bus.select_b), .sclk(bus.sclk),
    .mosi(bus.mosi), .miso(bus.miso), .miso_oe_b(bus.miso_oe_b));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    i_wr  <= 1'b1;
    @(posedge i_clock);
    i_wr  <= 1'b0;
    // One idle edge keeps back-to-back calls from driving the strobe twice.
    @(posedge i_clock);
  endtask
  // Bounded wait: a hung frame shows as a mismatch later, not a hang.
  task automatic waitf();
    repeat (2) @(posedge i_clock);
    for (int k = 0; k < 500 && bus.select_b !== 1'b1; k++)
      @(posedge i_clock);
    repeat (3) @(posedge i_clock);
  endtask
  task automatic frame(input logic [7:0] op);
    wr(REG_CMD, op);
    waitf();
  endtask
  task automatic sw(input logic [7:0] d);
    frame(OP_SET_LATCH);
    wr(REG_DATA, d);
    frame(OP_STATUS_WRITE);
  endtask
  task automatic rd(input logic [7:0] exp);
    addr <= REG_CMD;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge i_clock);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    lvl     <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk(status, STATUS_SHIPPED);
    frame(OP_SET_LATCH);
    chk(status, 8'h02);
    frame(OP_CLEAR_LATCH);
    chk(status, 8'h00);
    wr(REG_DATA, 8'h0C);
    frame(OP_STATUS_WRITE);
    chk(status, 8'h00);
    // Pin held low with the pin guard off must not block writes.
    foreach (rows[i]) begin
      sw(rows[i][23:16]);
      aaddr <= rows[i][15:1];
      repeat (2) @(posedge i_clock);
      chk(status, rows[i][23:16]);
      chk({7'h00, ok}, {7'h00, rows[i][0]});
    end
    sw(8'hF3);
    chk(status, 8'h80);
    sw(8'h0C);
    chk(status, 8'h80);
    saved   <= 3'h5;
    lvl     <= 1'b1;
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk(status, 8'h84);
    frame(OP_SET_LATCH);
    wr(REG_DATA, 8'h0C);
    wr(REG_CMD, OP_STATUS_WRITE);
    repeat (70) @(posedge i_clock);
    lvl <= 1'b0;
    waitf();
    chk(status, 8'h0C);
    busy <= 1'b1;
    frame(OP_STATUS_READ);
    rd(8'h0D);
    busy <= 1'b0;
    frame(OP_STATUS_READ);
    rd(8'h0C);
    foreach (ops[i]) begin
      frame(OP_SET_LATCH);
      frame(ops[i]);
      chk(status, 8'h0C);
    end
    stop_test();
  end
endmodule // tb_top
